// ### hdl/swsc_if.sv
// Interface joining the fieldbus master end and the slave end
`timescale 1ns/10ps
`default_nettype none
interface swsc_if;
  logic reg_req;
  logic reg_wr;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_ack;
  logic [15:0] reg_rdata;
  logic st_req;
  swsc_pkg::swsc_state_e st_target;
  swsc_pkg::swsc_state_e st_cur;
  logic st_ack;
  logic st_err;
  logic pd_valid;
  logic [15:0] pd_out;
  logic pd_ok;
  logic [15:0] pd_in;
  logic mbx_valid;
  logic mbx_kind;
  logic mbx_ok;
  modport master (output reg_req, reg_wr, reg_addr, reg_wdata, st_req, st_target,
    pd_valid, pd_out, mbx_valid, mbx_kind,
    input reg_ack, reg_rdata, st_cur, st_ack, st_err, pd_ok, pd_in, mbx_ok);
  modport slave (input reg_req, reg_wr, reg_addr, reg_wdata, st_req, st_target,
    pd_valid, pd_out, mbx_valid, mbx_kind,
    output reg_ack, reg_rdata, st_cur, st_ack, st_err, pd_ok, pd_in, mbx_ok);
endinterface : swsc_if
`default_nettype wire

// ### hdl/swsc_master.sv
// Master end: APB-controlled register and state requests toward the slave
`timescale 1ns/10ps
`default_nettype none
module swsc_master
  import swsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  swsc_if.master bus
);
  import swsc_pkg::*;

  logic [31:0] data_r, rdat_r, prdata_r;
  logic [2:0] ena_r;
  logic busy_r, isst_r, wr_r, err_r, pready_r;
  logic [11:0] adr_r;
  logic pd_valid_r, mbx_valid_r, mbx_kind_r;
  logic [15:0] pd_out_r;

  wire acc = psel && penable && !pready_r;
  wire wr_en = acc && pwrite;
  wire hit_ctrl = (paddr == SWSC_APB_CTRL);
  wire hit_data = (paddr == SWSC_APB_DATA);
  wire hit_stat = (paddr == SWSC_APB_STAT);
  wire hit_rdat = (paddr == SWSC_APB_RDAT);
  wire hit_ena = (paddr == SWSC_APB_ENA);
  wire hit_any = hit_ctrl | hit_data | hit_stat | hit_rdat | hit_ena;
  wire [11:0] go_adr = pwdata[SWSC_CTRL_ADR +: 12];
  // Setting writes without enable are never sent to the slave; reads still are
  wire blocked = (go_adr == SWSC_OFF_DIV && !ena_r[SWSC_ENA_DIV]) ||
    (go_adr == SWSC_OFF_LOC && !ena_r[SWSC_ENA_LOC]) ||
    (go_adr == SWSC_OFF_PRC && !ena_r[SWSC_ENA_PRC]);
  wire go = wr_en && hit_ctrl && pwdata[SWSC_CTRL_GO] && !busy_r;
  wire go_reg = go && !pwdata[SWSC_CTRL_ST] && !(pwdata[SWSC_CTRL_WR] && blocked);
  wire go_st = go && pwdata[SWSC_CTRL_ST];
  wire done = busy_r && (isst_r ? bus.st_ack : bus.reg_ack);
  wire [31:0] stat = {26'h000_0000, bus.st_err, bus.st_cur, err_r, busy_r};
  wire [31:0] rd = hit_data ? data_r : hit_stat ? stat : hit_rdat ? rdat_r :
    hit_ena ? {29'h0000_0000, ena_r} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      data_r <= '0;
      ena_r <= '0;
      rdat_r <= '0;
    end else begin
      pready_r <= acc;
      if (acc && !pwrite) prdata_r <= rd;
      if (wr_en && hit_data) data_r <= pwdata;
      if (wr_en && hit_ena) ena_r <= pwdata[2:0];
      if (done && !isst_r) rdat_r <= {16'h0000, bus.reg_rdata};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      isst_r <= 1'b0;
      wr_r <= 1'b0;
      adr_r <= '0;
      err_r <= 1'b0;
    end else begin
      if (go_reg || go_st) begin
        busy_r <= 1'b1;
        isst_r <= go_st;
        wr_r <= pwdata[SWSC_CTRL_WR];
        adr_r <= go_adr;
      end else if (done) begin
        busy_r <= 1'b0;
      end
      if (go && !go_reg && !go_st) err_r <= 1'b1;
      else if (go) err_r <= 1'b0;
    end
  end

  // Process data and mailbox strobes pulse one cycle per DATA write with bit 31 or bit 30 set; output data held for the slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_valid_r <= 1'b0;
      pd_out_r <= '0;
      mbx_valid_r <= 1'b0;
      mbx_kind_r <= SWSC_MBX_GEN;
    end else begin
      pd_valid_r <= wr_en && hit_data && pwdata[31];
      mbx_valid_r <= wr_en && hit_data && pwdata[30];
      mbx_kind_r <= pwdata[29];
      if (wr_en && hit_data) pd_out_r <= pwdata[15:0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = 1'b0;
  assign bus.reg_req = busy_r && !isst_r;
  assign bus.reg_wr = wr_r;
  assign bus.reg_addr = adr_r;
  assign bus.reg_wdata = data_r[15:0];
  assign bus.st_req = busy_r && isst_r;
  assign bus.st_target = swsc_state_e'(adr_r[2:0]);
  assign bus.pd_valid = pd_valid_r;
  assign bus.pd_out = pd_out_r;
  assign bus.mbx_valid = mbx_valid_r;
  assign bus.mbx_kind = mbx_kind_r;
endmodule : swsc_master
`default_nettype wire

// ### hdl/swsc_pkg.sv
// Package: register map, states, timing constants for the slave watchdog block
package swsc_pkg;
  localparam int unsigned SWSC_BASE_CLK_HZ = 25_000_000;
  localparam int unsigned SWSC_PCLK_HZ = 125_000_000;
  localparam int unsigned SWSC_PRE_CNT = SWSC_PCLK_HZ / SWSC_BASE_CLK_HZ;
  localparam logic [2:0] SWSC_PRE_MAX = 3'(SWSC_PRE_CNT - 1);
  localparam logic [15:0] SWSC_TICK_EXTRA = 16'h0002;
  localparam int unsigned SWSC_DEFAULT_TIMEOUT_MS = 100;
  localparam int unsigned SWSC_MAX_TIMEOUT_S = 170;

  // Slave-side register offsets
  localparam logic [11:0] SWSC_OFF_DIV = 12'h0400;
  localparam logic [11:0] SWSC_OFF_LOC = 12'h0410;
  localparam logic [11:0] SWSC_OFF_PRC = 12'h0420;
  localparam logic [15:0] SWSC_RST_DIV = 16'h09c2;
  localparam logic [15:0] SWSC_RST_LOC = 16'h03e8;
  localparam logic [15:0] SWSC_RST_PRC = 16'h03e8;
  localparam logic [15:0] SWSC_ZERO16 = 16'h0000;

  // Controller APB registers
  localparam logic [11:0] SWSC_APB_CTRL = 12'h0000;
  localparam logic [11:0] SWSC_APB_DATA = 12'h0004;
  localparam logic [11:0] SWSC_APB_STAT = 12'h0008;
  localparam logic [11:0] SWSC_APB_RDAT = 12'h000c;
  localparam logic [11:0] SWSC_APB_ENA = 12'h0010;
  localparam int unsigned SWSC_CTRL_GO = 0;
  localparam int unsigned SWSC_CTRL_WR = 1;
  localparam int unsigned SWSC_CTRL_ST = 2;
  localparam int unsigned SWSC_CTRL_ADR = 16;
  localparam int unsigned SWSC_ENA_DIV = 0;
  localparam int unsigned SWSC_ENA_LOC = 1;
  localparam int unsigned SWSC_ENA_PRC = 2;

  typedef enum logic [2:0] {
    SWSC_ST_INIT = 3'b000,
    SWSC_ST_PREOP = 3'b001,
    SWSC_ST_SAFEOP = 3'b010,
    SWSC_ST_OP = 3'b011,
    SWSC_ST_BOOT = 3'b100
  } swsc_state_e;

  // Mailbox kinds
  localparam logic SWSC_MBX_GEN = 1'b0;
  localparam logic SWSC_MBX_FILE = 1'b1;
endpackage : swsc_pkg

// ### hdl/swsc_slave.sv
// Slave end: watchdogs, tick divider, slave state machine, output gating
`timescale 1ns/10ps
`default_nettype none
module swsc_slave
  import swsc_pkg::*;
#(
  parameter int W = 16,
  parameter logic [W-1:0] SAFE_VALUE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  swsc_if.slave bus,
  input wire logic loc_xfer,
  input wire logic [W-1:0] loc_inputs,
  input wire logic mbx_cfg_ok,
  input wire logic pd_cfg_ok,
  output logic [W-1:0] phys_out,
  output logic loc_tripped,
  output logic prc_tripped,
  output logic [W-1:0] loc_outputs
);
  import swsc_pkg::*;

  logic [15:0] div_r, loc_cnt_r, prc_cnt_r;
  logic [2:0] pre_r;
  logic [16:0] tdiv_r;
  logic tick_r;
  logic reg_ack_r, st_ack_r, st_err_r, pd_ok_r, mbx_ok_r;
  logic [15:0] reg_rdata_r, pd_in_r;
  swsc_state_e st_r, st_nxt;
  logic [W-1:0] out_data_r, phys_r, loc_out_r;
  logic loc_trip, prc_trip;

  // Base clock enable at 25 MHz, then a tick every divider+2 base periods
  wire base_en = (pre_r == SWSC_PRE_MAX);
  // One bit wider so a divider of 65535 does not wrap the tick length
  wire [16:0] tick_len = {1'b0, div_r} + {1'b0, SWSC_TICK_EXTRA} - 17'h0_0001;
  wire tick_end = base_en && (tdiv_r >= tick_len);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
      tdiv_r <= '0;
      tick_r <= 1'b0;
    end else begin
      pre_r <= base_en ? 3'b000 : pre_r + 3'b001;
      tick_r <= tick_end;
      if (base_en) begin
        tdiv_r <= tick_end ? 17'h0_0000 : tdiv_r + 17'h0_0001;
      end
    end
  end

  // Register access; writes accepted in any state
  wire reg_take = bus.reg_req && !reg_ack_r;
  wire hit_div = (bus.reg_addr == SWSC_OFF_DIV);
  wire hit_loc = (bus.reg_addr == SWSC_OFF_LOC);
  wire hit_prc = (bus.reg_addr == SWSC_OFF_PRC);
  wire [15:0] rd_mux = hit_div ? div_r : hit_loc ? loc_cnt_r : hit_prc ? prc_cnt_r : 16'h0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= SWSC_RST_DIV;
      loc_cnt_r <= SWSC_RST_LOC;
      prc_cnt_r <= SWSC_RST_PRC;
      reg_ack_r <= 1'b0;
      reg_rdata_r <= '0;
    end else begin
      reg_ack_r <= reg_take;
      if (reg_take && bus.reg_wr && hit_div) div_r <= bus.reg_wdata;
      if (reg_take && bus.reg_wr && hit_loc) loc_cnt_r <= bus.reg_wdata;
      if (reg_take && bus.reg_wr && hit_prc) prc_cnt_r <= bus.reg_wdata;
      if (reg_take) reg_rdata_r <= rd_mux;
    end
  end

  // Traffic permissions per state
  wire pd_allowed = (st_r == SWSC_ST_SAFEOP) || (st_r == SWSC_ST_OP);
  wire mbx_allowed = (st_r == SWSC_ST_PREOP) || pd_allowed ||
    ((st_r == SWSC_ST_BOOT) && (bus.mbx_kind == SWSC_MBX_FILE));
  wire pd_good = bus.pd_valid && pd_allowed;

  swsc_wdog #(.W(16)) u_prc_wdog (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_r),
    .kick(pd_good),
    .limit(prc_cnt_r),
    .tripped(prc_trip)
  );
  swsc_wdog #(.W(16)) u_loc_wdog (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_r),
    .kick(loc_xfer),
    .limit(loc_cnt_r),
    .tripped(loc_trip)
  );

  // State machine; a trip never moves the state
  wire t = bus.st_req && !st_ack_r;
  wire [2:0] tgt = bus.st_target;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SWSC_ST_INIT: begin
        if (tgt == SWSC_ST_PREOP && mbx_cfg_ok) st_nxt = SWSC_ST_PREOP;
        else if (tgt == SWSC_ST_BOOT) st_nxt = SWSC_ST_BOOT;
      end
      SWSC_ST_PREOP: begin
        if (tgt == SWSC_ST_SAFEOP && pd_cfg_ok) st_nxt = SWSC_ST_SAFEOP;
        else if (tgt == SWSC_ST_INIT) st_nxt = SWSC_ST_INIT;
      end
      SWSC_ST_SAFEOP: begin
        if (tgt == SWSC_ST_OP) st_nxt = SWSC_ST_OP;
        else if (tgt == SWSC_ST_PREOP || tgt == SWSC_ST_INIT) st_nxt = swsc_state_e'(tgt);
      end
      SWSC_ST_OP: begin
        // Unused target codes must never reach the state register
        if (tgt == SWSC_ST_INIT || tgt == SWSC_ST_PREOP || tgt == SWSC_ST_SAFEOP) begin
          st_nxt = swsc_state_e'(tgt);
        end
      end
      SWSC_ST_BOOT: begin
        if (tgt == SWSC_ST_INIT) st_nxt = SWSC_ST_INIT;
      end
      default: st_nxt = SWSC_ST_INIT;
    endcase
  end
  wire st_bad = (st_nxt != swsc_state_e'(tgt));
  wire enter_safeop = t && (st_r == SWSC_ST_PREOP) && (st_nxt == SWSC_ST_SAFEOP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= SWSC_ST_INIT;
      st_ack_r <= 1'b0;
      st_err_r <= 1'b0;
      pd_in_r <= '0;
      pd_ok_r <= 1'b0;
      mbx_ok_r <= 1'b0;
      out_data_r <= SAFE_VALUE;
    end else begin
      st_ack_r <= t;
      if (t) begin
        st_r <= st_nxt;
        st_err_r <= st_bad;
      end
      // Inputs copied on the same edge that raises the acknowledge, and cyclically once running
      if (enter_safeop || pd_allowed) pd_in_r <= 16'(loc_inputs);
      pd_ok_r <= pd_good;
      mbx_ok_r <= bus.mbx_valid && mbx_allowed;
      if (pd_good) out_data_r <= W'(bus.pd_out);
    end
  end

  // Output forcing; count zero means monitoring off
  wire wd_off = (prc_cnt_r == SWSC_ZERO16);
  // Either watchdog trip forces the safe value on phys_out; loc_outputs keeps following the output data
  wire drive_op = (st_r == SWSC_ST_OP) && !prc_trip && !loc_trip;
  wire drive_safeop = (st_r == SWSC_ST_SAFEOP) && wd_off && !loc_trip;
  wire [W-1:0] phys_nxt = (drive_op || drive_safeop) ? out_data_r : SAFE_VALUE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phys_r <= SAFE_VALUE;
      loc_out_r <= SAFE_VALUE;
    end else begin
      phys_r <= phys_nxt;
      loc_out_r <= out_data_r;
    end
  end

  assign bus.reg_ack = reg_ack_r;
  assign bus.reg_rdata = reg_rdata_r;
  assign bus.st_cur = st_r;
  assign bus.st_ack = st_ack_r;
  assign bus.st_err = st_err_r;
  assign bus.pd_ok = pd_ok_r;
  assign bus.pd_in = pd_in_r;
  assign bus.mbx_ok = mbx_ok_r;
  assign phys_out = phys_r;
  assign loc_tripped = loc_trip;
  assign prc_tripped = prc_trip;
  assign loc_outputs = loc_out_r;
endmodule : swsc_slave
`default_nettype wire

// ### hdl/swsc_wdog.sv
// One timeout watchdog counting shared ticks
`timescale 1ns/10ps
`default_nettype none
module swsc_wdog
  import swsc_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic kick,
  input wire logic [W-1:0] limit,
  output logic tripped
);
  logic [W-1:0] cnt_r;
  logic tripped_r;
  wire disabled = (limit == W'(0));
  wire at_limit = (cnt_r >= limit);
  assign tripped = tripped_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tripped_r <= 1'b0;
    end else if (kick || disabled) begin
      cnt_r <= '0;
      tripped_r <= 1'b0;
    end else if (tick && !tripped_r) begin
      if (cnt_r + W'(1) >= limit) begin
        tripped_r <= 1'b1;
      end
      cnt_r <= at_limit ? cnt_r : cnt_r + W'(1);
    end
  end
endmodule : swsc_wdog
`default_nettype wire

// ### verif/slave_watchdog_state_control_tb.sv
// Self-checking bench: APB driven master end facing the slave end
`timescale 1ns/10ps
`default_nettype none
module slave_watchdog_state_control_tb;
  import swsc_pkg::*;
  typedef struct {
    swsc_state_e tgt;
    logic cfg, err;
    swsc_state_e st;
    logic gen, file, pd, drv;
  } swsc_row_s;
  // Target, setup ok, refused, state after, general mbx, file mbx, data ok, outputs live
  swsc_row_s rows [9] = '{
    '{SWSC_ST_BOOT, 1, 0, SWSC_ST_BOOT, 0, 1, 0, 0},
    '{SWSC_ST_INIT, 1, 0, SWSC_ST_INIT, 0, 0, 0, 0},
    '{SWSC_ST_OP, 1, 1, SWSC_ST_INIT, 0, 0, 0, 0},
    '{SWSC_ST_PREOP, 0, 1, SWSC_ST_INIT, 0, 0, 0, 0},
    '{SWSC_ST_PREOP, 1, 0, SWSC_ST_PREOP, 1, 1, 0, 0},
    '{SWSC_ST_SAFEOP, 0, 1, SWSC_ST_PREOP, 1, 1, 0, 0},
    '{SWSC_ST_SAFEOP, 1, 0, SWSC_ST_SAFEOP, 1, 1, 1, 0},
    '{SWSC_ST_OP, 1, 0, SWSC_ST_OP, 1, 1, 1, 1},
    '{SWSC_ST_BOOT, 1, 1, SWSC_ST_OP, 1, 1, 1, 1}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, loc_xfer = 1, cfg_ok = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, loc_tripped, prc_tripped;
  logic [15:0] loc_inputs = '0, phys_out, loc_outputs;
  int err_count = 0, checked = 0, n_mbx = 0, n_pd = 0, m;
  logic [11:0] offs [3] = '{SWSC_OFF_DIV, SWSC_OFF_LOC, SWSC_OFF_PRC};
  logic [15:0] rsts [3] = '{SWSC_RST_DIV, SWSC_RST_LOC, SWSC_RST_PRC};
  always #4 pclk = ~pclk;
  swsc_if link();
  swsc_master u_swsc_master (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(link));
  swsc_slave u_swsc_slave (.pclk(pclk), .presetn(presetn), .bus(link), .loc_xfer(loc_xfer),
    .loc_inputs(loc_inputs), .mbx_cfg_ok(cfg_ok), .pd_cfg_ok(cfg_ok), .phys_out(phys_out),
    .loc_tripped(loc_tripped), .prc_tripped(prc_tripped), .loc_outputs(loc_outputs));
  swsc_properties u_swsc_properties (.pclk(pclk), .presetn(presetn), .reg_req(link.reg_req),
    .reg_ack(link.reg_ack), .st_req(link.st_req), .st_ack(link.st_ack), .st_cur(link.st_cur),
    .pd_valid(link.pd_valid), .pd_ok(link.pd_ok), .mbx_valid(link.mbx_valid),
    .mbx_kind(link.mbx_kind), .mbx_ok(link.mbx_ok));
  always @(posedge pclk) begin
    if (link.mbx_ok === 1'b1) n_mbx++;
    if (link.pd_ok === 1'b1) n_pd++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Called just after a rising edge; idles one cycle after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Issues a control word, then polls busy; leaves status in r
  task automatic ctrl(input logic [31:0] c);
    apb(1, SWSC_APB_CTRL, c);
    do begin
      apb(0, SWSC_APB_STAT, 0);
    end while (r[0] !== 1'b0);
  endtask
  task automatic sreg(input logic w, input logic [11:0] a, input logic [15:0] d);
    apb(1, SWSC_APB_DATA, {16'h0000, d});
    ctrl((32'(a) << 16) | (32'(w) << 1) | 32'h0000_0001);
    apb(0, SWSC_APB_RDAT, 0);
  endtask
  task automatic send(input logic [31:0] d);
    apb(1, SWSC_APB_DATA, d);
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(link.st_cur, SWSC_ST_INIT);
    foreach (rows[i]) begin
      cfg_ok <= rows[i].cfg;
      loc_inputs <= 16'ha5a0 + 16'(i);
      ctrl((32'(rows[i].tgt) << 16) | 32'h0000_0005);
      chk(r[4:2], rows[i].st);
      chk(r[5], rows[i].err);
      m = n_mbx;
      send(32'h4000_0000);
      chk(n_mbx - m, rows[i].gen);
      m = n_mbx;
      send(32'h6000_0000);
      chk(n_mbx - m, rows[i].file);
      m = n_pd;
      send(32'h8000_1230 + i);
      chk(n_pd - m, rows[i].pd);
      chk(phys_out, rows[i].drv ? 16'h1230 + 16'(i) : 16'h0000);
      if (rows[i].pd) chk(link.pd_in, loc_inputs);
    end
    foreach (offs[k]) begin
      sreg(0, offs[k], 0);
      chk(r[15:0], rsts[k]);
    end
    // Downloads stay off until enabled
    sreg(1, SWSC_OFF_DIV, 16'h0001);
    apb(0, SWSC_APB_STAT, 0);
    chk(r[1], 1'b1);
    chk(pslverr, 1'b0);
    sreg(0, SWSC_OFF_DIV, 0);
    chk(r[15:0], SWSC_RST_DIV);
    apb(1, SWSC_APB_ENA, 32'h0000_0007);
    foreach (offs[k]) begin
      sreg(1, offs[k], k == 0 ? 16'h0000 : 16'h0003);
      sreg(0, offs[k], 0);
      chk(r[15:0], k == 0 ? 16'h0000 : 16'h0003);
    end
    // Tick 10 pclk, timeout 30 pclk
    send(32'h8000_0111);
    chk(prc_tripped, 1'b0);
    repeat (60) @(posedge pclk);
    chk(prc_tripped, 1'b1);
    chk(loc_tripped, 1'b0);
    chk(phys_out, 16'h0000);
    apb(0, SWSC_APB_STAT, 0);
    chk(r[4:2], SWSC_ST_OP);
    send(32'h8000_0222);
    chk(prc_tripped, 1'b0);
    chk(phys_out, 16'h0222);
    loc_xfer <= 0;
    repeat (60) @(posedge pclk);
    chk(loc_tripped, 1'b1);
    loc_xfer <= 1;
    repeat (3) @(posedge pclk);
    chk(loc_tripped, 1'b0);
    sreg(1, SWSC_OFF_PRC, 16'h0000);
    send(32'h8000_0333);
    repeat (80) @(posedge pclk);
    chk(prc_tripped, 1'b0);
    chk(phys_out, 16'h0333);
    // Local silence alone also forces the safe value
    loc_xfer <= 0;
    repeat (60) @(posedge pclk);
    chk(loc_tripped, 1'b1);
    chk(prc_tripped, 1'b0);
    chk(phys_out, 16'h0000);
    loc_xfer <= 1;
    repeat (3) @(posedge pclk);
    chk(phys_out, 16'h0333);
    chk(loc_outputs, 16'h0333);
    // Monitoring off lets Safe-Op drive outputs
    ctrl((32'(SWSC_ST_SAFEOP) << 16) | 32'h0000_0005);
    chk(r[4:2], SWSC_ST_SAFEOP);
    send(32'h8000_0444);
    chk(phys_out, 16'h0444);
    sreg(1, SWSC_OFF_PRC, 16'h0003);
    chk(phys_out, 16'h0000);
    sreg(1, SWSC_OFF_LOC, 16'hffff);
    sreg(0, SWSC_OFF_LOC, 0);
    chk(r[15:0], 16'hffff);
    // Reset in mid-run returns to init with safe outputs
    presetn <= 0;
    repeat (3) @(posedge pclk);
    chk(link.st_cur, SWSC_ST_INIT);
    chk(phys_out, 16'h0000);
    presetn <= 1;
    @(posedge pclk);
    chk(phys_out, 16'h0000);
    sreg(0, SWSC_OFF_LOC, 0);
    chk(r[15:0], SWSC_RST_LOC);
    final_report();
  end
endmodule // slave_watchdog_state_control_tb
`default_nettype wire

// ### verif/swsc_properties.sv
// Concurrent checks on the link between the master end and the slave end
`timescale 1ns/10ps
`default_nettype none
module swsc_properties
  import swsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reg_req,
  input wire logic reg_ack,
  input wire logic st_req,
  input wire logic st_ack,
  input wire swsc_pkg::swsc_state_e st_cur,
  input wire logic pd_valid,
  input wire logic pd_ok,
  input wire logic mbx_valid,
  input wire logic mbx_kind,
  input wire logic mbx_ok
);
  import swsc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Data states, where process traffic must be answered
  wire logic pd_open = (st_cur == SWSC_ST_SAFEOP) || (st_cur == SWSC_ST_OP);
  a_reg_ack_next: assert property ($rose(reg_req) |=> reg_ack)
    else $error("register access not acknowledged next cycle");
  a_reg_ack_pulse: assert property (reg_ack |=> !reg_ack)
    else $error("register acknowledge longer than one cycle");
  a_st_ack_next: assert property ($rose(st_req) |=> st_ack)
    else $error("state request not acknowledged next cycle");
  a_init_no_traffic: assert property ((st_cur == SWSC_ST_INIT) && (pd_valid || mbx_valid)
    |=> !pd_ok && !mbx_ok) else $error("traffic accepted in init");
  a_preop_mbx_only: assert property ((st_cur == SWSC_ST_PREOP) && mbx_valid |=> mbx_ok)
    else $error("mailbox refused in pre-op");
  a_preop_no_pd: assert property ((st_cur == SWSC_ST_PREOP) && pd_valid |=> !pd_ok)
    else $error("process data accepted in pre-op");
  a_data_open: assert property (pd_open && pd_valid |=> pd_ok)
    else $error("process data refused in a data state");
  a_boot_file_only: assert property ((st_cur == SWSC_ST_BOOT) && mbx_valid
    |=> mbx_ok == $past(mbx_kind)) else $error("wrong mailbox answer in boot");
  a_boot_no_pd: assert property ((st_cur == SWSC_ST_BOOT) && pd_valid |=> !pd_ok)
    else $error("process data accepted in boot");
  a_boot_entry: assert property ($changed(st_cur) && (st_cur == SWSC_ST_BOOT)
    |-> $past(st_cur) == SWSC_ST_INIT) else $error("boot entered from a state other than init");
  a_state_on_ack: assert property ($changed(st_cur) |-> st_ack)
    else $error("state changed without a state acknowledge");
  c_boot_file: cover property ((st_cur == SWSC_ST_BOOT) && mbx_ok);
  c_preop_mbx: cover property ((st_cur == SWSC_ST_PREOP) && mbx_ok);
  c_op_data: cover property ((st_cur == SWSC_ST_OP) && pd_ok);
endmodule // swsc_properties
`default_nettype wire
